// ---- tps_pkg.sv ----
package tps_pkg;
   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [3:0] PRESCALE_COUNT_VALUE_ADDR = 4'hA;
   localparam logic [7:0] PRESCALE_COUNT_RESET = 8'hFF;
   // Cycles after reset before count-source edges are trusted
   localparam logic [1:0] SRC_ARM_COUNT = 2'h3;
   // Mode register reset: bits 7..0 = 1 0 1 1 1 111
   localparam logic [7:0] MODE_RESET = 8'hBF;
   localparam int LOW_OSC_BIT = 7;
   localparam int SPARE_BIT = 6;
   localparam int SOURCE_BIT = 5;
   localparam int EDGE_BIT = 4;
   localparam int ASSIGN_BIT = 3;
   localparam int RATE_LSB = 0;

   typedef struct packed {
      logic low_osc_source_select;
      logic spare_storage_bit;
      logic timer_source_select;
      logic count_edge_select;
      logic prescale_assign_watchdog;
      logic [2:0] prescale_rate_select;
   } tps_mode_t;

   // Instruction port to the mode register
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] data;
   } tps_mode_cmd_t;
endpackage

// ---- tps_sync.sv ----
`timescale 1ns/1ps
module tps_sync (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_d,
   output logic o_q
);
   logic s1_reg;
   logic s2_reg;
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
      end else begin
         s1_reg <= i_d;
         s2_reg <= s1_reg;
      end
   end
   assign o_q = s2_reg;
endmodule

// ---- tps_timer0_prescaler.sv ----
`timescale 1ns/1ps
// What this block does
// - The mode register is written and read only by its two instructions.
// - Serving the timer, rate codes 000..111 divide by 2 up to 256.
// - Serving watchdog reset timeout, codes divide by 1 up to 128.
// - Serving watchdog interrupt timeout, codes divide by 2 up to 256.
// - Assign bit 1 gives the prescaler to the watchdog, 0 to the timer.
// - Edge bit 1 counts falling pin edges, 0 counts rising pin edges.
// - The edge bit also picks the counted edge of the low oscillator.
// - Source bit 0 clocks from instruction clock, 1 from pin or low osc.
// - With source 1, low-osc bit 0 picks the pin, 1 the low oscillator.
// - The count register reads the live 8-bit prescaler, reset all ones.
module tps_timer0_prescaler (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire tps_pkg::tps_mode_cmd_t i_mode_cmd,
   input wire logic i_reg_rd,
   input wire logic [3:0] i_reg_addr,
   input wire logic i_inst_tick,
   input wire logic i_ext_count_pin,
   input wire logic i_low_osc,
   input wire logic i_wdt_tick,
   input wire logic i_wdt_irq_mode,
   input wire logic i_timer_enable,
   output logic [7:0] o_mode_rdata,
   output logic [7:0] o_reg_rdata,
   output logic o_timer_tick,
   output logic o_wdt_tick
);
   // ---------------------------------------------------------------
   // Mode register
   // ---------------------------------------------------------------
   tps_pkg::tps_mode_t mode_reg;
   tps_pkg::tps_mode_t mode_next;
   logic [7:0] mode_rdata_reg;
   logic [7:0] mode_rdata_next;

   always_comb begin
      mode_next = mode_reg;
      mode_rdata_next = mode_rdata_reg;
      if (i_mode_cmd.wr) begin
         mode_next = tps_pkg::tps_mode_t'(i_mode_cmd.data);
      end
      if (i_mode_cmd.rd) begin
         mode_rdata_next = mode_reg;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         mode_reg <= tps_pkg::tps_mode_t'(tps_pkg::MODE_RESET);
         mode_rdata_reg <= 8'h00;
      end else begin
         mode_reg <= mode_next;
         mode_rdata_reg <= mode_rdata_next;
      end
   end

   // ---------------------------------------------------------------
   // Source selection and edge detection
   // ---------------------------------------------------------------
   logic pin_s;
   logic osc_s;
   logic src_d_reg;
   logic src_d_next;
   logic src_lvl;
   logic src_edge;
   logic timer_src;
   logic [1:0] arm_reg;
   logic [1:0] arm_next;

   tps_sync u_sync_pin (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_d(i_ext_count_pin),
      .o_q(pin_s)
   );
   tps_sync u_sync_osc (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_d(i_low_osc),
      .o_q(osc_s)
   );

   always_comb begin
      src_lvl = mode_reg.low_osc_source_select ? osc_s : pin_s;
      src_d_next = src_lvl;
      // Falling edge when edge bit is 1, else rising
      if (mode_reg.count_edge_select) begin
         src_edge = src_d_reg & ~src_lvl;
      end else begin
         src_edge = ~src_d_reg & src_lvl;
      end
      // Synchroniser and edge history reset low; a pin idling high would
      // look like a rising edge, so edges wait until both have settled
      arm_next = arm_reg;
      if (arm_reg != tps_pkg::SRC_ARM_COUNT) begin
         arm_next = arm_reg + 2'h1;
         src_edge = 1'b0;
      end
      timer_src = mode_reg.timer_source_select ? src_edge
                                               : i_inst_tick;
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         src_d_reg <= 1'b0;
         arm_reg <= 2'h0;
      end else begin
         src_d_reg <= src_d_next;
         arm_reg <= arm_next;
      end
   end

   // ---------------------------------------------------------------
   // Shared prescaler
   // ---------------------------------------------------------------
   // Counter runs upward; tap k fires when bit k-1 rolls 1->0, so tap k
   // divides by 2^k (tap 0 every input). Watchdog reset mode uses the tap one lower.
   logic [7:0] pcnt_reg;
   logic [7:0] pcnt_next;
   logic [7:0] pcnt_inc;
   logic to_wdt;
   logic pre_in;
   logic [3:0] tap;
   logic tap_fire;
   logic timer_tick_reg;
   logic timer_tick_next;
   logic wdt_tick_reg;
   logic wdt_tick_next;
   logic [7:0] reg_rdata_reg;
   logic [7:0] reg_rdata_next;

   always_comb begin
      to_wdt = mode_reg.prescale_assign_watchdog;
      pre_in = to_wdt ? i_wdt_tick : (timer_src & i_timer_enable);
      pcnt_inc = pcnt_reg + 8'h01;
      pcnt_next = pre_in ? pcnt_inc : pcnt_reg;
      if (to_wdt && !i_wdt_irq_mode) begin
         tap = {1'b0, mode_reg.prescale_rate_select};
      end else begin
         tap = {1'b0, mode_reg.prescale_rate_select} + 4'h1;
      end
      if (tap == 4'h0) begin
         tap_fire = pre_in;
      end else begin
         tap_fire = pre_in & (&pcnt_reg[tap[2:0] - 3'h1 -: 1])
                    & (pcnt_inc[tap[2:0] - 3'h1] == 1'b0);
         if (tap[2:0] == 3'h0) begin
            tap_fire = pre_in & (pcnt_reg == 8'hFF);
         end
      end
      timer_tick_next = tap_fire & ~to_wdt;
      wdt_tick_next = tap_fire & to_wdt;
      reg_rdata_next = 8'h00;
      if (i_reg_rd && i_reg_addr == tps_pkg::PRESCALE_COUNT_VALUE_ADDR) begin
         reg_rdata_next = pcnt_reg;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         pcnt_reg <= tps_pkg::PRESCALE_COUNT_RESET;
         timer_tick_reg <= 1'b0;
         wdt_tick_reg <= 1'b0;
         reg_rdata_reg <= 8'h00;
      end else begin
         pcnt_reg <= pcnt_next;
         timer_tick_reg <= timer_tick_next;
         wdt_tick_reg <= wdt_tick_next;
         reg_rdata_reg <= reg_rdata_next;
      end
   end

   assign o_mode_rdata = mode_rdata_reg;
   assign o_reg_rdata = reg_rdata_reg;
   assign o_timer_tick = timer_tick_reg;
   assign o_wdt_tick = wdt_tick_reg;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   a_mode_write: assert property (i_mode_cmd.wr |=>
      mode_reg == $past(i_mode_cmd.data)) else $error("mode write lost");
   a_mode_read: assert property (i_mode_cmd.rd |=>
      o_mode_rdata == $past(mode_reg)) else $error("mode read wrong");
   a_timer_owner: assert property (o_timer_tick |->
      !$past(mode_reg.prescale_assign_watchdog)) else $error("timer tick");
   a_wdt_owner: assert property (o_wdt_tick |->
      $past(mode_reg.prescale_assign_watchdog)) else $error("wdt tick");
   a_wdt_div1: assert property ((to_wdt && !i_wdt_irq_mode &&
      mode_reg.prescale_rate_select == 3'h0 && i_wdt_tick) |=> o_wdt_tick)
      else $error("wdt 1:1 missed");
   a_div2_even: assert property ((!to_wdt && i_timer_enable &&
      mode_reg.prescale_rate_select == 3'h0 && pre_in && !pcnt_reg[0])
      |=> !o_timer_tick) else $error("1:2 fired early");
   a_count_read: assert property ((i_reg_rd && i_reg_addr ==
      tps_pkg::PRESCALE_COUNT_VALUE_ADDR) |=> o_reg_rdata == $past(pcnt_reg))
      else $error("count read wrong");
   a_count_hold: assert property (!pre_in |=>
      pcnt_reg == $past(pcnt_reg)) else $error("prescaler moved");
   a_inst_src: assert property ((!mode_reg.timer_source_select) |->
      timer_src == i_inst_tick) else $error("source select");
   a_wrap_fire: assert property ((!to_wdt && pre_in &&
      mode_reg.prescale_rate_select == 3'h7 && pcnt_reg == 8'hFF)
      |=> o_timer_tick) else $error("1:256 tick missed");
   a_count_step: assert property (pre_in |=>
      pcnt_reg == $past(pcnt_reg) + 8'h01) else $error("prescaler skipped");
   a_idle_rdata: assert property ((!i_reg_rd || i_reg_addr !=
      tps_pkg::PRESCALE_COUNT_VALUE_ADDR) |=> o_reg_rdata == 8'h00)
      else $error("stray read data");
   a_timer_quiet: assert property (to_wdt |=> !o_timer_tick)
      else $error("timer tick while watchdog owns");
   a_wdt_quiet: assert property (!to_wdt |=> !o_wdt_tick)
      else $error("watchdog tick while timer owns");

   c_timer_tick: cover property (o_timer_tick);
   c_wdt_tick: cover property (o_wdt_tick);
   c_ext_edge: cover property (mode_reg.timer_source_select && src_edge);
   c_wrap: cover property (!to_wdt && pre_in && pcnt_reg == 8'hFF);
   c_low_osc: cover property (mode_reg.low_osc_source_select && src_edge);
endmodule

// ---- tps_count_source.sv ----
`timescale 1ns/1ps
module tps_count_source (
   input wire logic i_clk,
   input wire logic i_level,
   input wire logic i_sel_osc,
   input wire logic i_slow,
   output logic o_pin,
   output logic o_osc
);
   // Edges land off the core clock phase, as a free-running pin would
   initial begin
      o_pin = 1'b0;
      o_osc = 1'b0;
      forever begin
         @(posedge i_clk);
         if ((i_sel_osc ? o_osc : o_pin) !== i_level) begin
            repeat (i_slow ? 7 : 1) @(posedge i_clk);
            #37;
            if (i_sel_osc) o_osc = i_level;
            else o_pin = i_level;
         end
      end
   end
endmodule

// ---- timer0_prescaler_clock_select_tb_top.sv ----
`timescale 1ns/1ps
module timer0_prescaler_clock_select_tb_top;
   typedef struct packed {
      logic [7:0] mode;
      logic irq;
      logic [8:0] exp;
   } tps_row_t;
   logic i_clk, i_rstn, i_reg_rd, i_inst_tick, i_wdt_tick, i_wdt_irq_mode;
   logic i_timer_enable, lvl, sel_osc, slow, pin, osc, o_timer_tick;
   logic o_wdt_tick;
   tps_pkg::tps_mode_cmd_t i_mode_cmd;
   logic [3:0] i_reg_addr;
   logic [7:0] o_mode_rdata, o_reg_rdata, cnt_exp;
   int n_mismatch, checks, n_tt, n_wt;
   tps_row_t rows [24];

   tps_timer0_prescaler dut (.i_clk(i_clk), .i_rstn(i_rstn),
      .i_mode_cmd(i_mode_cmd), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
      .i_inst_tick(i_inst_tick), .i_ext_count_pin(pin), .i_low_osc(osc),
      .i_wdt_tick(i_wdt_tick), .i_wdt_irq_mode(i_wdt_irq_mode),
      .i_timer_enable(i_timer_enable), .o_mode_rdata(o_mode_rdata),
      .o_reg_rdata(o_reg_rdata), .o_timer_tick(o_timer_tick),
      .o_wdt_tick(o_wdt_tick));
   tps_count_source far (.i_clk(i_clk), .i_level(lvl), .i_sel_osc(sel_osc),
      .i_slow(slow), .o_pin(pin), .o_osc(osc));

   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      if (o_timer_tick === 1'b1) n_tt++;
      if (o_wdt_tick === 1'b1) n_wt++;
   end
   initial begin
      #2_000_000;
      n_mismatch++;
      stop_test();
   end

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task step;
      @(posedge i_clk);
      #1;
   endtask
   task chk(input string nm, input logic [8:0] e, input logic [8:0] s);
      checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %0h seen %0h", nm, e, s);
      end
   endtask
   task wr_mode(input logic [7:0] d);
      i_mode_cmd = '{1'b1, 1'b0, d};
      step();
      i_mode_cmd.wr = 1'b0;
   endtask
   task rd_mode(input logic [7:0] e);
      i_mode_cmd.rd = 1'b1;
      step();
      i_mode_cmd.rd = 1'b0;
      chk("mode", {1'b0, e}, {1'b0, o_mode_rdata});
      step();
   endtask
   task rd_cnt(input logic [3:0] a, input logic [7:0] e);
      i_reg_addr = a;
      i_reg_rd = 1'b1;
      step();
      i_reg_rd = 1'b0;
      chk("count", {1'b0, e}, {1'b0, o_reg_rdata});
      step();
   endtask
   task pulses(input int n);
      i_inst_tick = 1'b1;
      i_wdt_tick = 1'b1;
      repeat (n) step();
      i_inst_tick = 1'b0;
      i_wdt_tick = 1'b0;
      repeat (3) step();
   endtask
   task stop_test;
      if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Sequence
   // ---------------------------------------------------------------
   initial begin
      {i_rstn, i_reg_rd, i_inst_tick, i_wdt_tick, i_wdt_irq_mode} = '0;
      {lvl, sel_osc, slow, i_mode_cmd, i_reg_addr} = '0;
      i_timer_enable = 1'b1;
      cnt_exp = 8'hFF;
      for (int k = 0; k < 24; k++)
         rows[k] = '{{4'h0, k / 8 != 0, 3'(k % 8)}, k / 8 == 2,
            9'(((k / 8) == 1 ? 256 : 128) >> (k % 8))};
      repeat (20) @(posedge i_clk);
      #1 i_rstn = 1'b1;
      step();
      rd_mode(8'hBF);
      rd_cnt(4'hA, 8'hFF);
      rd_cnt(4'h9, 8'h00);
      i_mode_cmd = '{1'b1, 1'b1, 8'h5A};
      step();
      i_mode_cmd = '0;
      chk("mode", {1'b0, 8'hBF}, {1'b0, o_mode_rdata});
      step();
      rd_mode(8'h5A);
      // Every tap divides 256, so the tally is phase independent
      foreach (rows[k]) begin
         i_wdt_irq_mode = rows[k].irq;
         wr_mode(rows[k].mode);
         n_tt = 0;
         n_wt = 0;
         pulses(256);
         chk("ticks", rows[k].exp, rows[k].mode[3] ? n_wt[8:0] : n_tt[8:0]);
         chk("idle", 9'h000, rows[k].mode[3] ? n_tt[8:0] : n_wt[8:0]);
         rd_cnt(4'hA, cnt_exp);
      end
      wr_mode(8'h20);
      pulses(10);
      rd_cnt(4'hA, cnt_exp);
      for (int s = 0; s < 4; s++) begin
         sel_osc = s[1];
         slow = s[0];
         wr_mode({s[1], 2'b01, s[0], 4'h0});
         lvl = 1'b1;
         cnt_exp += 8'(!s[0]);
         repeat (12) step();
         rd_cnt(4'hA, cnt_exp);
         lvl = 1'b0;
         cnt_exp += 8'(s[0]);
         repeat (12) step();
         rd_cnt(4'hA, cnt_exp);
      end
      i_rstn = 1'b0;
      repeat (2) step();
      i_rstn = 1'b1;
      step();
      rd_mode(8'hBF);
      rd_cnt(4'hA, 8'hFF);
      stop_test();
   end
endmodule
